// ==== verilog/transport_regs_pkg.sv ====
package transport_regs_pkg;
   // Register byte offsets.
   localparam logic [11:0] OFF_OFFER_WORD = 12'h010;
   localparam logic [11:0] OFF_OFFER_SEL = 12'h014;
   localparam logic [11:0] OFF_ACCEPT_WORD = 12'h020;
   localparam logic [11:0] OFF_ACCEPT_SEL = 12'h024;
   localparam logic [11:0] OFF_RING_SELECT = 12'h030;
   localparam logic [11:0] OFF_RING_SIZE_LIMIT = 12'h034;
   localparam logic [11:0] OFF_RING_SIZE = 12'h038;
   localparam logic [11:0] OFF_RING_ENABLE = 12'h044;
   localparam logic [11:0] OFF_RING_DOORBELL = 12'h050;
   localparam logic [11:0] OFF_EVENT_CAUSE = 12'h060;
   localparam logic [11:0] OFF_EVENT_CLEAR = 12'h064;
   localparam logic [11:0] OFF_DEVICE_PROGRESS = 12'h070;
   localparam logic [11:0] OFF_LIST_LO = 12'h080;
   localparam logic [11:0] OFF_LIST_HI = 12'h084;
   localparam logic [11:0] OFF_OFFER_RING_LO = 12'h090;
   localparam logic [11:0] OFF_OFFER_RING_HI = 12'h094;
   localparam logic [11:0] OFF_DONE_RING_LO = 12'h0A0;
   localparam logic [11:0] OFF_DONE_RING_HI = 12'h0A4;
   localparam logic [11:0] OFF_SETTINGS_VERSION = 12'h0FC;
   localparam logic [11:0] OFF_SETTINGS_BASE = 12'h100;
   // Ring and capability geometry.
   localparam int NUM_RINGS = 4;
   localparam int RING_IDX_W = 2;
   localparam logic [31:0] NUM_RINGS_W = 32'h0000_0004;
   localparam int CAP_WORDS = 2;
   localparam logic [31:0] CAP_WORDS_W = 32'h0000_0002;
   localparam logic [15:0] RING_SIZE_LIMIT = 16'h0100;
   // Settings space geometry.
   localparam int SETTINGS_BYTES = 64;
   localparam int SETTINGS_AW = 6;
   // Event cause bit positions.
   localparam int CAUSE_RING_BIT = 0;
   localparam int CAUSE_SETTINGS_BIT = 1;
   localparam int CAUSE_W = 2;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : transport_regs_pkg

// ==== verilog/paravirt_mmio_transport_regs.sv ====
module paravirt_mmio_transport_regs
   import transport_regs_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Driver memory-mapped access.
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [11:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic [3:0] bus_be,
   output logic [31:0] bus_rdata,
   output logic bus_rvalid,
   // Capabilities.
   input wire logic [63:0] offered_caps,
   output logic [63:0] accepted_caps,
   // Device-side events and settings updates.
   input wire logic ring_update_evt,
   input wire logic dev_set_we,
   input wire logic [5:0] dev_set_addr,
   input wire logic [7:0] dev_set_data,
   // Ring engine view.
   input wire logic [1:0] query_ring,
   output logic [3:0] ring_enables,
   output logic [15:0] query_size,
   output logic [63:0] query_list_addr,
   output logic [63:0] query_offer_addr,
   output logic [63:0] query_done_addr,
   output logic doorbell_valid,
   output logic [31:0] doorbell_index,
   // Device state.
   output logic [31:0] progress_flags,
   output logic device_reset_pulse,
   output logic irq
);

   // Selectors written by the driver.
   logic [31:0] offer_sel_r;
   logic [31:0] accept_sel_r;
   logic [31:0] ring_select_r;

   // Accepted capability bits, both groups.
   logic [63:0] accepted_r;

   // Per-ring copies, one entry for each supported queue.
   logic [15:0] size_r [NUM_RINGS];
   logic [NUM_RINGS-1:0] enable_r;
   logic [63:0] list_r [NUM_RINGS];
   logic [63:0] offer_r [NUM_RINGS];
   logic [63:0] done_r [NUM_RINGS];

   // Event causes and their next value.
   logic [CAUSE_W-1:0] cause_r;
   logic [CAUSE_W-1:0] cause_nxt;

   // Driver progress, settings version and the settings bytes.
   logic [31:0] progress_r;
   logic [31:0] version_r;
   logic [7:0] settings_r [SETTINGS_BYTES];

   // Registered read answer.
   logic [31:0] rdata_r;
   logic rvalid_r;

   // Doorbell pulse, reset announcement and interrupt line.
   logic bell_r;
   logic [31:0] bell_idx_r;
   logic soft_rst_r;
   logic irq_r;

   // Registered view of the ring that the engine queries.
   logic [15:0] q_size_r;
   logic [63:0] q_list_r;
   logic [63:0] q_offer_r;
   logic [63:0] q_done_r;

   // Decode of the current access.
   // It is combinational, so every register below sees the same view of one request.
   logic sel_ok;
   logic [RING_IDX_W-1:0] sel_idx;
   logic soft_rst;
   logic in_settings;
   logic [SETTINGS_AW-1:0] set_word;
   logic drv_set_wr;
   logic settings_change;

   assign sel_ok = ring_select_r < NUM_RINGS_W;
   assign sel_idx = ring_select_r[RING_IDX_W-1:0];
   assign soft_rst = bus_wr && bus_addr == OFF_DEVICE_PROGRESS && bus_wdata == ZERO_WORD;
   assign in_settings = bus_addr >= OFF_SETTINGS_BASE &&
                        bus_addr < OFF_SETTINGS_BASE + 12'(SETTINGS_BYTES);
   assign set_word = {bus_addr[SETTINGS_AW-1:2], 2'b00};
   assign drv_set_wr = bus_wr && in_settings && bus_be != 4'h0;
   // A driver write or a device-side update both count as a settings change.
   assign settings_change = drv_set_wr || dev_set_we;

   // Feature selectors; any reset returns both to the first group.
   // Values past the last group are stored as written; their users check the range.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         offer_sel_r <= ZERO_WORD;
         accept_sel_r <= ZERO_WORD;
      end else if (bus_wr) begin
         if (bus_addr == OFF_OFFER_SEL) begin
            offer_sel_r <= bus_wdata;
         end
         if (bus_addr == OFF_ACCEPT_SEL) begin
            accept_sel_r <= bus_wdata;
         end
      end
   end

   // Accepted capabilities; a selector past the last group writes nothing.
   // Only bit 0 then steers the write, as the range check has already passed.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         accepted_r <= 64'h0000_0000_0000_0000;
      end else if (bus_wr && bus_addr == OFF_ACCEPT_WORD && accept_sel_r < CAP_WORDS_W) begin
         accepted_r[accept_sel_r[0]*32 +: 32] <= bus_wdata;
      end
   end

   // Ring selector.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         ring_select_r <= ZERO_WORD;
      end else if (bus_wr && bus_addr == OFF_RING_SELECT) begin
         ring_select_r <= bus_wdata;
      end
   end

   // Per-ring storage; writes to a queue that does not exist are dropped.
   // Nothing here stops a rewrite of an enabled ring; the driver is trusted with that.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         for (int i = 0; i < NUM_RINGS; i++) begin
            size_r[i] <= 16'h0000;
            list_r[i] <= 64'h0000_0000_0000_0000;
            offer_r[i] <= 64'h0000_0000_0000_0000;
            done_r[i] <= 64'h0000_0000_0000_0000;
         end
      end else if (bus_wr && sel_ok) begin
         unique case (bus_addr)
            OFF_RING_SIZE: size_r[sel_idx] <= bus_wdata[15:0];
            OFF_LIST_LO: list_r[sel_idx][31:0] <= bus_wdata;
            OFF_LIST_HI: list_r[sel_idx][63:32] <= bus_wdata;
            OFF_OFFER_RING_LO: offer_r[sel_idx][31:0] <= bus_wdata;
            OFF_OFFER_RING_HI: offer_r[sel_idx][63:32] <= bus_wdata;
            OFF_DONE_RING_LO: done_r[sel_idx][31:0] <= bus_wdata;
            OFF_DONE_RING_HI: done_r[sel_idx][63:32] <= bus_wdata;
            default: ;
         endcase
      end
   end

   // Ring enables clear on any reset so no engine touches stale rings.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         enable_r <= '0;
      end else if (bus_wr && sel_ok && bus_addr == OFF_RING_ENABLE) begin
         enable_r[sel_idx] <= bus_wdata[0];
      end
   end

   // Doorbell strobe, high for one cycle after each doorbell write.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         bell_r <= 1'b0;
      end else begin
         bell_r <= bus_wr && bus_addr == OFF_RING_DOORBELL;
      end
   end

   // Doorbell index holds, so an engine that is slow to look still finds it.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         bell_idx_r <= ZERO_WORD;
      end else if (bus_wr && bus_addr == OFF_RING_DOORBELL) begin
         bell_idx_r <= bus_wdata;
      end
   end

   // Event causes: a new event in the acknowledge cycle wins over the clear.
   always_comb begin
      cause_nxt = cause_r;
      if (bus_wr && bus_addr == OFF_EVENT_CLEAR) begin
         cause_nxt = cause_nxt & ~bus_wdata[CAUSE_W-1:0];
      end
      if (ring_update_evt) begin
         cause_nxt[CAUSE_RING_BIT] = 1'b1;
      end
      if (dev_set_we) begin
         cause_nxt[CAUSE_SETTINGS_BIT] = 1'b1;
      end
   end

   // Cause register, cleared by any reset.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         cause_r <= '0;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // Interrupt line follows the same next value, so it never lags the causes by a cycle.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |cause_nxt;
      end
   end

   // Progress flags accumulate; zero is the reset command, not a value.
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         progress_r <= ZERO_WORD;
      end else if (bus_wr && bus_addr == OFF_DEVICE_PROGRESS) begin
         progress_r <= progress_r | bus_wdata;
      end
   end

   // Reset announcement for the rest of the device.
   always_ff @(posedge clk) begin
      if (rst) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= soft_rst;
      end
   end

   // Version counter; it only moves forward, so a retried read always differs.
   // A 32-bit wrap would take billions of changes, far beyond any retry window.
   always_ff @(posedge clk) begin
      if (rst) begin
         version_r <= ZERO_WORD;
      end else if (settings_change) begin
         version_r <= version_r + 32'h0000_0001;
      end
   end

   // Settings bytes; a device update to the same byte wins over the driver.
   // Soft reset leaves these bytes alone; they belong to the device, not the driver.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < SETTINGS_BYTES; i++) begin
            settings_r[i] <= 8'h00;
         end
      end else begin
         if (drv_set_wr) begin
            for (int k = 0; k < 4; k++) begin
               if (bus_be[k]) begin
                  settings_r[set_word + SETTINGS_AW'(k)] <= bus_wdata[8*k +: 8];
               end
            end
         end
         if (dev_set_we) begin
            settings_r[dev_set_addr] <= dev_set_data;
         end
      end
   end

   // Read strobe answer, exactly one cycle after each read request.
   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= bus_rd;
      end
   end

   // Read data; unmapped and write-only offsets read as zero.
   // The data holds until the next read, so a slow master may take it late.
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= ZERO_WORD;
      end else begin
         if (bus_rd) begin
            rdata_r <= ZERO_WORD;
            if (in_settings) begin
               for (int k = 0; k < 4; k++) begin
                  rdata_r[8*k +: 8] <= settings_r[set_word + SETTINGS_AW'(k)];
               end
            end else begin
               unique case (bus_addr)
                  OFF_OFFER_WORD: begin
                     if (offer_sel_r < CAP_WORDS_W) begin
                        rdata_r <= offered_caps[offer_sel_r[0]*32 +: 32];
                     end
                  end
                  OFF_RING_SIZE_LIMIT: begin
                     if (sel_ok) begin
                        rdata_r <= {16'h0000, RING_SIZE_LIMIT};
                     end
                  end
                  OFF_RING_ENABLE: begin
                     if (sel_ok) begin
                        rdata_r <= {31'h0000_0000, enable_r[sel_idx]};
                     end
                  end
                  OFF_EVENT_CAUSE: rdata_r <= {30'h0000_0000, cause_r};
                  OFF_DEVICE_PROGRESS: rdata_r <= progress_r;
                  OFF_SETTINGS_VERSION: rdata_r <= version_r;
                  default: ;
               endcase
            end
         end
      end
   end

   // Registered view of one ring for the engine that walks it.
   // The copy lags query_ring by one cycle, which keeps every output a flip-flop.
   always_ff @(posedge clk) begin
      if (rst) begin
         q_size_r <= 16'h0000;
         q_list_r <= 64'h0000_0000_0000_0000;
         q_offer_r <= 64'h0000_0000_0000_0000;
         q_done_r <= 64'h0000_0000_0000_0000;
      end else begin
         q_size_r <= size_r[query_ring];
         q_list_r <= list_r[query_ring];
         q_offer_r <= offer_r[query_ring];
         q_done_r <= done_r[query_ring];
      end
   end

   // Driver bus answer.
   assign bus_rdata = rdata_r;
   assign bus_rvalid = rvalid_r;

   // Capability and ring state for the rest of the device.
   assign accepted_caps = accepted_r;
   assign ring_enables = enable_r;

   // Engine view of the queried ring.
   assign query_size = q_size_r;
   assign query_list_addr = q_list_r;
   assign query_offer_addr = q_offer_r;
   assign query_done_addr = q_done_r;

   // Doorbell, progress, reset and interrupt, each straight from its flip-flop.
   assign doorbell_valid = bell_r;
   assign doorbell_index = bell_idx_r;
   assign progress_flags = progress_r;
   assign device_reset_pulse = soft_rst_r;
   assign irq = irq_r;

endmodule : paravirt_mmio_transport_regs

// ==== sim/transport_regs_assertions.sv ====
module transport_regs_assertions
   import transport_regs_pkg::*;
(
   // Clock, reset and driver bus.
   input wire logic clk,
   input wire logic rst,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [11:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   // Device events and watched outputs.
   input wire logic ring_update_evt,
   input wire logic dev_set_we,
   input wire logic bus_rvalid,
   input wire logic doorbell_valid,
   input wire logic [31:0] doorbell_index,
   input wire logic [3:0] ring_enables,
   input wire logic [31:0] progress_flags,
   input wire logic device_reset_pulse,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // A write with no device event beside it, so set-wins-over-clear cannot mask a slip.
   sequence quiet_wr_s(logic [11:0] a);
      bus_wr && bus_addr == a && !ring_update_evt && !dev_set_we;
   endsequence
   read_answer_a: assert property (bus_rd |=> bus_rvalid)
      else $error("read not answered");
   doorbell_pulse_a: assert property (bus_wr && bus_addr == OFF_RING_DOORBELL |=>
      doorbell_valid && doorbell_index == $past(bus_wdata)) else $error("doorbell lost");
   ring_cause_a: assert property (ring_update_evt && !bus_wr |=> irq)
      else $error("ring event not flagged");
   set_cause_a: assert property (dev_set_we && !bus_wr |=> irq)
      else $error("settings event not flagged");
   cause_hold_a: assert property (irq && !bus_wr |=> irq)
      else $error("cause dropped without clear");
   ack_clear_a: assert property (quiet_wr_s(OFF_EVENT_CLEAR) ##0 bus_wdata[1:0] == 2'h3
      |=> !irq) else $error("clear left cause");
   progress_or_a: assert property (quiet_wr_s(OFF_DEVICE_PROGRESS) ##0 bus_wdata != 0
      |=> progress_flags == ($past(progress_flags) | $past(bus_wdata))) else $error("flags");
   soft_reset_a: assert property (quiet_wr_s(OFF_DEVICE_PROGRESS) ##0 bus_wdata == 0
      |=> device_reset_pulse && !irq && ring_enables == 4'h0) else $error("soft reset");
endmodule : transport_regs_assertions

bind paravirt_mmio_transport_regs transport_regs_assertions chk_u (.clk, .rst, .bus_wr,
   .bus_rd, .bus_addr, .bus_wdata, .ring_update_evt, .dev_set_we, .bus_rvalid, .doorbell_valid,
   .doorbell_index, .ring_enables, .progress_flags, .device_reset_pulse, .irq);

// ==== sim/test_paravirt_mmio_transport_regs.sv ====
module test_paravirt_mmio_transport_regs
   import transport_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Stimulus starts idle, with reset held.
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [11:0] bus_addr = 12'h000;
   logic [31:0] bus_wdata = 32'h0;
   logic [3:0] bus_be = 4'hF;
   logic [63:0] offered_caps = 64'hA5A5_0F0F_1234_5678;
   logic ring_update_evt = 1'b0;
   logic dev_set_we = 1'b0;
   logic [5:0] dev_set_addr = 6'h08;
   logic [7:0] dev_set_data = 8'h5A;
   logic [1:0] query_ring = 2'h0;
   logic [31:0] bus_rdata, doorbell_index, progress_flags;
   logic bus_rvalid, doorbell_valid, device_reset_pulse, irq;
   logic [63:0] accepted_caps, query_list_addr, query_offer_addr, query_done_addr;
   logic [3:0] ring_enables;
   logic [15:0] query_size;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;

   always #50 clk = ~clk;

   paravirt_mmio_transport_regs dut_u (.clk, .rst, .bus_wr, .bus_rd, .bus_addr, .bus_wdata,
      .bus_be, .bus_rdata, .bus_rvalid, .offered_caps, .accepted_caps, .ring_update_evt,
      .dev_set_we, .dev_set_addr, .dev_set_data, .query_ring, .ring_enables, .query_size,
      .query_list_addr, .query_offer_addr, .query_done_addr, .doorbell_valid, .doorbell_index,
      .progress_flags, .device_reset_pulse, .irq);

   // A hang is cut short well beyond the fewer than two hundred cycles the run needs.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         wrap_up();
      end
   end

   // Inputs always move 10 ns after a rising edge, away from sampling.
   task automatic step;
      @(posedge clk);
      #10;
   endtask : step

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Each access leaves one idle cycle, so no strobe is driven twice in a time step.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      step();
      bus_wr = 1'b1;
      bus_addr = a;
      bus_wdata = d;
      step();
      bus_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      step();
      bus_rd = 1'b1;
      bus_addr = a;
      step();
      bus_rd = 1'b0;
      d = bus_rdata;
   endtask : rd

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask : rc

   function automatic logic [31:0] pat(int i, int j);
      return i * 256 + j;
   endfunction : pat

   task automatic pulse_evt;
      step();
      ring_update_evt = 1'b1;
      step();
      ring_update_evt = 1'b0;
   endtask : pulse_evt

   task automatic t_caps;
      wr(OFF_OFFER_SEL, 32'h0);
      rc(OFF_OFFER_WORD, 32'h1234_5678);
      wr(OFF_OFFER_SEL, 32'h1);
      rc(OFF_OFFER_WORD, 32'hA5A5_0F0F);
      wr(OFF_ACCEPT_SEL, 32'h1);
      wr(OFF_ACCEPT_WORD, 32'hCAFE_0001);
      wr(OFF_ACCEPT_SEL, 32'h0);
      wr(OFF_ACCEPT_WORD, 32'h0000_BEEF);
      chk(accepted_caps, 64'hCAFE_0001_0000_BEEF);
      wr(OFF_ACCEPT_SEL, 32'h2);
      wr(OFF_ACCEPT_WORD, 32'hFFFF_FFFF);
      chk(accepted_caps, 64'hCAFE_0001_0000_BEEF);
      wr(OFF_OFFER_SEL, 32'h2);
      rc(OFF_OFFER_WORD, 32'h0);
   endtask : t_caps

   // Every ring gets its own pattern, so a shared copy shows up at once.
   task automatic t_rings;
      logic [11:0] offs [6];
      offs = '{OFF_LIST_LO, OFF_LIST_HI, OFF_OFFER_RING_LO, OFF_OFFER_RING_HI,
         OFF_DONE_RING_LO, OFF_DONE_RING_HI};
      for (int i = 0; i < NUM_RINGS; i++) begin
         wr(OFF_RING_SELECT, i);
         wr(OFF_RING_SIZE, i + 16);
         for (int j = 0; j < 6; j++) begin
            wr(offs[j], pat(i, j));
         end
         wr(OFF_RING_ENABLE, 32'h1);
      end
      chk(ring_enables, 4'hF);
      for (int i = 0; i < NUM_RINGS; i++) begin
         query_ring = 2'(i);
         step();
         chk(query_size, i + 16);
         chk(query_list_addr, {pat(i, 1), pat(i, 0)});
         chk(query_offer_addr, {pat(i, 3), pat(i, 2)});
         chk(query_done_addr, {pat(i, 5), pat(i, 4)});
      end
      wr(OFF_RING_SELECT, 32'h2);
      wr(OFF_RING_ENABLE, 32'h0);
      rc(OFF_RING_ENABLE, 32'h0);
      rc(OFF_RING_SIZE_LIMIT, 32'h100);
      wr(OFF_RING_SELECT, 32'h1);
      rc(OFF_RING_ENABLE, 32'h1);
      wr(OFF_RING_SELECT, 32'h4);
      rc(OFF_RING_SIZE_LIMIT, 32'h0);
      chk(ring_enables, 4'hB);
   endtask : t_rings

   task automatic t_bell;
      wr(OFF_RING_DOORBELL, 32'h3);
      chk({doorbell_valid, doorbell_index}, {1'b1, 32'h3});
      step();
      chk(doorbell_valid, 1'b0);
   endtask : t_bell

   task automatic t_events;
      logic [31:0] v0, v1;
      rc(OFF_EVENT_CAUSE, 32'h0);
      pulse_evt();
      chk(irq, 1'b1);
      rc(OFF_EVENT_CAUSE, 32'h1);
      rd(OFF_SETTINGS_VERSION, v0);
      step();
      dev_set_we = 1'b1;
      step();
      dev_set_we = 1'b0;
      rd(OFF_SETTINGS_VERSION, v1);
      chk(v1 !== v0, 1'b1);
      rc(OFF_SETTINGS_BASE + 12'h008, 32'h0000_005A);
      rc(OFF_EVENT_CAUSE, 32'h3);
      wr(OFF_EVENT_CLEAR, 32'h1);
      rc(OFF_EVENT_CAUSE, 32'h2);
      wr(OFF_EVENT_CLEAR, 32'h3);
      chk(irq, 1'b0);
      // An event in the clear cycle must survive that clear.
      step();
      bus_wr = 1'b1;
      bus_addr = OFF_EVENT_CLEAR;
      bus_wdata = 32'h1;
      ring_update_evt = 1'b1;
      step();
      bus_wr = 1'b0;
      ring_update_evt = 1'b0;
      rc(OFF_EVENT_CAUSE, 32'h1);
      wr(OFF_EVENT_CLEAR, 32'h1);
      chk(irq, 1'b0);
   endtask : t_events

   // A one-lane write must leave the other three bytes of the word alone.
   task automatic t_settings;
      logic [31:0] v0;
      rd(OFF_SETTINGS_VERSION, v0);
      wr(OFF_SETTINGS_BASE + 12'h004, 32'h1122_3344);
      bus_be = 4'h2;
      wr(OFF_SETTINGS_BASE + 12'h004, 32'h0000_AB00);
      bus_be = 4'hF;
      rc(OFF_SETTINGS_BASE + 12'h004, 32'h1122_AB44);
      rc(OFF_SETTINGS_VERSION, v0 + 32'h2);
      rc(12'h140, 32'h0);
      rc(OFF_ACCEPT_SEL, 32'h0);
   endtask : t_settings

   task automatic t_soft;
      wr(OFF_DEVICE_PROGRESS, 32'h1);
      wr(OFF_DEVICE_PROGRESS, 32'h4);
      rc(OFF_DEVICE_PROGRESS, 32'h5);
      pulse_evt();
      wr(OFF_DEVICE_PROGRESS, 32'h0);
      chk({device_reset_pulse, irq, ring_enables}, 6'h20);
      rc(OFF_EVENT_CAUSE, 32'h0);
      chk(device_reset_pulse, 1'b0);
      rc(OFF_RING_ENABLE, 32'h0);
      chk(progress_flags, 32'h0);
   endtask : t_soft

   task automatic wrap_up;
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // Reset for eight cycles, then the scenarios one after another.
   initial begin
      repeat (8) @(posedge clk);
      #10;
      rst = 1'b0;
      chk({irq, ring_enables, bus_rvalid}, 6'h0);
      t_caps();
      t_rings();
      t_bell();
      t_events();
      t_settings();
      t_soft();
      wrap_up();
   end
endmodule : test_paravirt_mmio_transport_regs
